/* hw/rbc_regs.vh */
`ifndef RBC_REGS_VH
`define RBC_REGS_VH
// self-test control register address and field positions
`define RBC_CTRL_ADDR 16'h0028
`define RBC_BIT_UNLOCK 15
`define RBC_BIT_FFAIL 14
`define RBC_SEL_HI 13
`define RBC_SEL_LO 11
`define RBC_BIT_START 10
`define RBC_BIT_PASS 9
`define RBC_BIT_FAIL 8
`define RBC_CTRL_RESET 16'h0000
// fields of the register implemented here (15:8)
`define RBC_RW_MASK 16'hFC00
// selector codes
`define RBC_SEL_IDLE0 3'b000
`define RBC_SEL_PATTERN 3'b001
`define RBC_SEL_WR0 3'b010
`define RBC_SEL_RD0 3'b011
`define RBC_SEL_WR1 3'b100
`define RBC_SEL_RD1 3'b101
`define RBC_SEL_INCDEC 3'b110
`define RBC_SEL_IDLE7 3'b111
// ram geometry
`define RBC_LAST_ADDR 13'h1FFF
`define RBC_ALL_ZERO 16'h0000
`define RBC_ALL_ONE 16'hFFFF
// nominal test times, in ns, at clock period in ns
`define RBC_CLK_NS 8
`define RBC_T_PATTERN_NS 7370000
`define RBC_T_WRITE_NS 82000
`define RBC_T_READ_NS 246000
`endif

/* hw/rbc_ram.v */
`timescale 1ns/1ps
`default_nettype none
// 8k x 16 single-port ram, one write port, registered read
module rbc_ram (
  input wire clk,
  input wire we,
  input wire [12:0] addr,
  input wire [15:0] wdata,
  output reg [15:0] rdata
);
  reg [15:0] mem [0:8191]; // storage array
  // registered read returns the old word when written in the same cycle
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

/* hw/rbc_ram_bist_control.v */
`timescale 1ns/1ps
`default_nettype none
`include "rbc_regs.vh"
module rbc_ram_bist_control (
  input wire clk,
  input wire rst,
  input wire soft_reset,
  input wire test_mode_pin,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_addr,
  input wire [15:0] host_wdata,
  input wire host_ram_wr,
  input wire [12:0] host_ram_addr,
  input wire [15:0] host_ram_wdata,
  input wire [15:0] host_ram_protect,
  output reg [15:0] host_rdata,
  output reg [15:0] host_ram_rdata,
  output reg full_ram_write_unlock,
  output reg bist_force_fail,
  output reg [2:0] bist_test_select,
  output reg bist_go,
  output reg bist_pass,
  output reg bist_fail
);
  // state codes
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WRITE = 3'd1;
  localparam [2:0] ST_RDWAIT = 3'd2;
  localparam [2:0] ST_CHECK = 3'd3;
  localparam [2:0] ST_DONE = 3'd4;
  reg pin_s1; // first sync stage
  reg pin_s2; // synchronised test pin
  reg [2:0] state; // sequencer state
  reg [12:0] addr; // current ram word
  reg [3:0] step; // pattern step 0..9
  reg err; // mismatch seen
  reg rmw; // step writes before checking
  reg ram_we; // ram write strobe
  reg [12:0] ram_addr; // ram address mux
  reg [15:0] ram_wdata; // ram write data
  wire [15:0] ram_rdata; // ram read data
  wire reg_hit; // host access to control register
  reg [15:0] next_ram_wdata; // host merged write data
  // pattern value for each step; step 0 is the clear pass
  function [15:0] pat;
    input [3:0] s;
    begin
      case (s)
        4'd1: pat = `RBC_ALL_ZERO;
        4'd2: pat = 16'h5555;
        4'd3: pat = 16'h3333;
        4'd4: pat = 16'h0F0F;
        4'd5: pat = 16'h00FF;
        4'd6: pat = 16'hAAAA;
        4'd7: pat = 16'hCCCC;
        4'd8: pat = 16'hF0F0;
        4'd9: pat = 16'hFF00;
        default: pat = `RBC_ALL_ZERO;
      endcase
    end
  endfunction
  // expected data for the current test
  function [15:0] expect_val;
    input [2:0] sel;
    input [3:0] s;
    begin
      case (sel)
        `RBC_SEL_RD1: expect_val = `RBC_ALL_ONE;
        `RBC_SEL_WR1: expect_val = `RBC_ALL_ONE;
        `RBC_SEL_PATTERN: expect_val = pat(s);
        `RBC_SEL_INCDEC: expect_val = pat(s);
        default: expect_val = `RBC_ALL_ZERO;
      endcase
    end
  endfunction
  assign reg_hit = pin_s2 && (host_addr == `RBC_CTRL_ADDR);
  // test pin synchroniser
  always @(posedge clk) begin
    if (rst) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= test_mode_pin;
      pin_s2 <= pin_s1;
    end
  end
  // host write merges around protected bits unless unlocked
  always @* begin
    next_ram_wdata = host_ram_wdata;
    if (!full_ram_write_unlock) begin
      next_ram_wdata = (host_ram_wdata & ~host_ram_protect) |
                       (ram_rdata & host_ram_protect);
    end else begin
      next_ram_wdata = host_ram_wdata;
    end
  end
  // ram port mux: bist owns the ram while running
  always @* begin
    if (bist_go) begin
      ram_addr = addr;
      ram_we = (state == ST_WRITE);
      ram_wdata = expect_val(bist_test_select, step);
    end else begin
      ram_addr = host_ram_addr;
      ram_we = host_ram_wr;
      ram_wdata = next_ram_wdata;
    end
  end
  // control fields and host register access
  always @(posedge clk) begin
    if (rst || soft_reset) begin
      full_ram_write_unlock <= 1'b0;
      bist_force_fail <= 1'b0;
      bist_test_select <= 3'b000;
      host_rdata <= `RBC_CTRL_RESET;
    end else begin
      if (host_wr && reg_hit && !bist_go) begin
        full_ram_write_unlock <= host_wdata[`RBC_BIT_UNLOCK];
        bist_force_fail <= host_wdata[`RBC_BIT_FFAIL];
        bist_test_select <= host_wdata[`RBC_SEL_HI:`RBC_SEL_LO];
      end
      if (host_rd && reg_hit) begin
        host_rdata <= {full_ram_write_unlock, bist_force_fail,
                       bist_test_select, bist_go, bist_pass,
                       bist_fail, 8'h00};
      end else if (host_rd) begin
        host_rdata <= `RBC_CTRL_RESET; // no function without test pin
      end
    end
  end
  // host ram read data path
  always @(posedge clk) begin
    if (rst) begin
      host_ram_rdata <= `RBC_ALL_ZERO;
    end else begin
      host_ram_rdata <= ram_rdata;
    end
  end
  // bist sequencer
  always @(posedge clk) begin
    if (rst || soft_reset) begin
      state <= ST_IDLE;
      bist_go <= 1'b0;
      bist_pass <= 1'b0;
      bist_fail <= 1'b0;
      addr <= 13'h0000;
      step <= 4'h0;
      err <= 1'b0;
      rmw <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (host_wr && reg_hit && host_wdata[`RBC_BIT_START] &&
              full_ram_write_unlock) begin
            bist_pass <= 1'b0;
            bist_fail <= 1'b0;
            err <= 1'b0;
            addr <= 13'h0000;
            case (host_wdata[`RBC_SEL_HI:`RBC_SEL_LO])
              `RBC_SEL_PATTERN: begin
                bist_go <= 1'b1;
                step <= 4'd0;
                rmw <= 1'b0;
                state <= ST_WRITE;
              end
              `RBC_SEL_INCDEC: begin
                bist_go <= 1'b1;
                step <= 4'd5;
                rmw <= 1'b1;
                state <= ST_WRITE;
              end
              `RBC_SEL_WR0, `RBC_SEL_WR1: begin
                bist_go <= 1'b1;
                state <= ST_WRITE;
              end
              `RBC_SEL_RD0, `RBC_SEL_RD1: begin
                bist_go <= 1'b1;
                state <= ST_RDWAIT;
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WRITE: begin
          // write-only tests and the pattern clear pass advance here
          if ((bist_test_select == `RBC_SEL_WR0) ||
              (bist_test_select == `RBC_SEL_WR1) ||
              ((bist_test_select == `RBC_SEL_PATTERN) && step == 4'd0))
          begin
            if (addr == `RBC_LAST_ADDR) begin
              addr <= 13'h0000;
              if (bist_test_select == `RBC_SEL_PATTERN) begin
                step <= 4'd1;
                state <= ST_RDWAIT;
              end else begin
                state <= ST_DONE;
              end
            end else begin
              addr <= addr + 13'h0001;
            end
          end else begin
            state <= ST_RDWAIT;
          end
        end
        ST_RDWAIT: begin
          state <= ST_CHECK; // ram read latency
        end
        ST_CHECK: begin
          if (ram_rdata != expect_val(bist_test_select, step)) begin
            err <= 1'b1;
          end
          if ((bist_test_select == `RBC_SEL_PATTERN ||
               bist_test_select == `RBC_SEL_INCDEC) &&
              !(step == 4'd9 || (rmw && step == 4'd8))) begin
            step <= step + 4'd1; // next pattern at same word
            state <= ST_WRITE;
          end else if (addr == `RBC_LAST_ADDR) begin
            state <= ST_DONE;
          end else begin
            addr <= addr + 13'h0001;
            if (bist_test_select == `RBC_SEL_PATTERN) begin
              step <= 4'd1;
              state <= ST_RDWAIT;
            end else if (bist_test_select == `RBC_SEL_INCDEC) begin
              step <= 4'd5;
              state <= ST_WRITE;
            end else begin
              state <= ST_RDWAIT;
            end
          end
        end
        ST_DONE: begin
          bist_go <= 1'b0;
          bist_fail <= err || bist_force_fail;
          bist_pass <= !(err || bist_force_fail);
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  rbc_ram u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );
endmodule
`default_nettype wire

/* dv/rbc_ram_bist_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rbc_ram_bist_control_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic test_mode_pin,
  input wire logic host_rd,
  input wire logic [15:0] host_addr,
  input wire logic [15:0] host_rdata,
  input wire logic full_ram_write_unlock,
  input wire logic bist_force_fail,
  input wire logic [2:0] bist_test_select,
  input wire logic bist_go,
  input wire logic bist_pass,
  input wire logic bist_fail
);
  // single domain, master reset masks everything
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // pin held long enough to cross the synchroniser
  sequence s_pin_low; !test_mode_pin [*3]; endsequence
  sequence s_pin_high; test_mode_pin [*3]; endsequence
  // a run that ended by itself, not by either reset
  sequence s_done;
    $fell(bist_go) && !$past(soft_reset) && !$past(rst);
  endsequence
  property p_soft_clear;
    soft_reset |=> {full_ram_write_unlock, bist_force_fail,
      bist_test_select, bist_go, bist_pass, bist_fail} == 8'h00;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft clear");
  property p_dead_reg;
    s_pin_low ##0 host_rd |=> host_rdata == 16'h0000;
  endproperty
  a_dead_reg: assert property (p_dead_reg) else $error("pin low read");
  property p_read_back;
    s_pin_high ##0 (host_rd && host_addr == 16'h0028) |=> host_rdata[15:11]
      == {full_ram_write_unlock, bist_force_fail, bist_test_select};
  endproperty
  a_read_back: assert property (p_read_back) else $error("read back");
  property p_start_unlock;
    $rose(bist_go) |-> $past(full_ram_write_unlock);
  endproperty
  a_start_unlock: assert property (p_start_unlock) else $error("unlock");
  property p_start_sel;
    $rose(bist_go) |-> !(bist_test_select inside {3'b000, 3'b111});
  endproperty
  a_start_sel: assert property (p_start_sel) else $error("idle start");
  property p_start_clear;
    $rose(bist_go) |-> ##[0:1] !(bist_pass || bist_fail);
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("stale");
  property p_min_run;
    $rose(bist_go) |-> bist_go [*8];
  endproperty
  a_min_run: assert property (p_min_run) else $error("short run");
  property p_sel_hold;
    bist_go && !soft_reset |=> $stable(bist_test_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("sel moved");
  property p_result;
    s_done |-> ##[0:1] (bist_pass ^ bist_fail);
  endproperty
  a_result: assert property (p_result) else $error("no result");
  property p_forced;
    s_done ##0 bist_force_fail |-> ##[0:1] (bist_fail && !bist_pass);
  endproperty
  a_forced: assert property (p_forced) else $error("not forced");
endmodule
bind rbc_ram_bist_control rbc_ram_bist_control_asserts u_chk (
  .clk(clk), .rst(rst), .soft_reset(soft_reset),
  .test_mode_pin(test_mode_pin), .host_rd(host_rd), .host_addr(host_addr),
  .host_rdata(host_rdata), .full_ram_write_unlock(full_ram_write_unlock),
  .bist_force_fail(bist_force_fail), .bist_test_select(bist_test_select),
  .bist_go(bist_go), .bist_pass(bist_pass), .bist_fail(bist_fail));
`default_nettype wire

/* dv/rbc_ram_bist_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module rbc_ram_bist_control_tb_top;
  logic clk = 0, rst = 1, srst = 0, pin = 0, wr = 0, rd = 0, rwr = 0;
  logic [15:0] ad = 16'h0028, wd = 0, rwd = 0, prot = 0, rdat, rrd;
  logic [12:0] ra = 0;
  logic ul, ff, go, ps, fl;
  logic [2:0] sel;
  int fail_count = 0, check_count = 0;
  rbc_ram_bist_control u_dut (.clk(clk), .rst(rst), .soft_reset(srst),
    .test_mode_pin(pin), .host_wr(wr), .host_rd(rd), .host_addr(ad),
    .host_wdata(wd), .host_ram_wr(rwr), .host_ram_addr(ra),
    .host_ram_wdata(rwd), .host_ram_protect(prot), .host_rdata(rdat),
    .host_ram_rdata(rrd), .full_ram_write_unlock(ul), .bist_force_fail(ff),
    .bist_test_select(sel), .bist_go(go), .bist_pass(ps), .bist_fail(fl));
  // 125 MHz clock
  initial forever #4 clk = ~clk;
  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one register write strobe
  task rw(input logic [15:0] d);
    @(posedge clk) begin wr <= 1; wd <= d; end
    @(posedge clk) wr <= 0;
  endtask
  // register read, data a cycle later
  task rr(input logic [15:0] e);
    @(posedge clk) rd <= 1;
    @(posedge clk) rd <= 0;
    #1 `CHK(rdat, e)
  endtask
  // ram read, data two cycles after address
  task mr(input logic [12:0] a, input logic [15:0] e);
    @(posedge clk) ra <= a;
    repeat (3) @(posedge clk);
    #1 `CHK(rrd, e)
  endtask
  // ram write once the merge read data has settled
  task mw(input logic [12:0] a, input logic [15:0] d, p);
    @(posedge clk) begin ra <= a; rwd <= d; prot <= p; end
    repeat (3) @(posedge clk);
    rwr <= 1;
    @(posedge clk) rwr <= 0;
  endtask
  // start a test, wait bounded for the end, judge pass/fail
  task run(input logic [15:0] d, input logic [1:0] e);
    int i;
    rw(d);
    #1 `CHK(go, 1'b1)
    for (i = 0; i < 30000 && go; i++) @(posedge clk);
    @(posedge clk);
    #1 `CHK({ps, fl}, e)
  endtask
  task t_pin_low;
    rw(16'h8000);
    rr(16'h0000);
    `CHK(ul, 1'b0)
    @(posedge clk) pin <= 1;
    repeat (3) @(posedge clk);
  endtask
  task t_locked;
    rw(16'h1400);
    repeat (3) @(posedge clk);
    #1 `CHK(go, 1'b0)
    rw(16'h8000);
    rr(16'h8000);
    // a write or read at another address must not reach the fields
    @(posedge clk) ad <= 16'h0000;
    rw(16'h0000);
    rr(16'h0000);
    @(posedge clk) ad <= 16'h0028;
    rr(16'h8000);
  endtask
  task t_fill;
    run(16'h9400, 2'b10);
    mr(13'h1fff, 16'h0000);
    run(16'h9c00, 2'b10);
    run(16'ha400, 2'b10);
    mr(13'h0000, 16'hffff);
    run(16'hac00, 2'b10);
    run(16'he400, 2'b01);
    rr(16'he100);
    `CHK({ul, ff, sel}, 5'h1c)
  endtask
  task t_idle;
    rw(16'h8400);
    repeat (3) @(posedge clk);
    #1 `CHK(go, 1'b0)
    rw(16'hbc00);
    repeat (3) @(posedge clk);
    #1 `CHK(go, 1'b0)
    mr(13'h0100, 16'hffff);
  endtask
  task t_protect;
    rw(16'h0000);
    rr(16'h0000);
    mw(13'h0005, 16'h0000, 16'hff00);
    mr(13'h0005, 16'hff00);
    rw(16'h8000);
    mw(13'h0005, 16'h0000, 16'hff00);
    mr(13'h0005, 16'h0000);
  endtask
  task t_abort;
    rw(16'h8c00);
    repeat (10) @(posedge clk);
    #1 `CHK(go, 1'b1)
    @(posedge clk) srst <= 1;
    @(posedge clk) srst <= 0;
    #1 `CHK({ul, ff, sel, go, ps, fl}, 8'h00)
    mr(13'h0000, 16'h0000);
    rw(16'h8000);
    rw(16'hb400);
    repeat (10) @(posedge clk);
    #1 `CHK(go, 1'b1)
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    #1 `CHK({ul, ff, sel, go, ps, fl}, 8'h00)
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    #1 `CHK({ul, ff, sel, go, ps, fl}, 8'h00)
    t_pin_low;
    t_locked;
    t_fill;
    t_idle;
    t_protect;
    t_abort;
    results;
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    results;
  end
endmodule
`default_nettype wire
